/* hw/rsreg_core.sv */
// recirculating serial shift register channels with select-gated output
// Summary of operation
// RULE1: each channel recirculates 1024 bits; one or two channels
// RULE2: write high, both selects low: take input bit
// RULE3: otherwise the leaving bit re-enters the register
// RULE4: selected: drive output; deselected: release shared line
// RULE5: controller keeps shift rate at or below 1 MHz
// RULE6: controller keeps shifting above minimum rate
// RULE7: one bit advance per applied clock cycle
`timescale 1ns/10ps
module rsreg_core #(
    parameter int CHANNELS = rsreg_pkg::CHAN_COUNT,
    parameter int BITS = rsreg_pkg::CHAN_BITS,
    parameter int DEPTH = rsreg_pkg::FIFO_DEPTH,
    parameter int HOLD_MAX = rsreg_pkg::HOLD_MAX_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // pins from ttl control logic
    input wire logic shift_clk,
    input wire logic [CHANNELS-1:0] data_in,
    input wire logic write_en,
    input wire logic sel_x_n,
    input wire logic sel_y_n,
    // shared output line, three signals
    output logic [CHANNELS-1:0] data_out,
    output logic [CHANNELS-1:0] data_out_oe,
    input wire logic [CHANNELS-1:0] data_out_in,
    // staged output bits for local consumer
    output logic bit_valid,
    input wire logic bit_ready,
    output logic [CHANNELS-1:0] bit_data,
    // status
    output logic rate_fault,
    output logic hold_fault,
    output logic stage_overflow
);
    localparam int GW = $clog2(rsreg_pkg::SHIFT_GAP_CYC + 1);
    localparam int HW = $clog2(HOLD_MAX + 1);
    localparam logic [GW-1:0] GAP = GW'(rsreg_pkg::SHIFT_GAP_CYC);
    localparam logic [HW-1:0] HOLD = HW'(HOLD_MAX);

    logic [2:0] clk_sync;
    logic [1:0] wr_sync;
    logic [1:0] sx_sync;
    logic [1:0] sy_sync;
    logic [CHANNELS-1:0] d_s1;
    logic [CHANNELS-1:0] d_s2;
    logic shift_pulse;
    logic selected;
    logic take_input;
    logic [BITS-1:0] ring [CHANNELS];
    logic [CHANNELS-1:0] tail;
    logic [CHANNELS-1:0] next_head;
    logic [GW-1:0] gap_cnt;
    logic [HW-1:0] hold_cnt;
    logic fifo_in_ready;
    logic unused_out_in;

    // two-flop synchronisers, third stage for edge detect
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            clk_sync <= 3'h0;
            wr_sync <= 2'h0;
            sx_sync <= 2'h3;
            sy_sync <= 2'h3;
            d_s1 <= '0;
            d_s2 <= '0;
        end else begin
            clk_sync <= {clk_sync[1:0], shift_clk};
            wr_sync <= {wr_sync[0], write_en};
            sx_sync <= {sx_sync[0], sel_x_n};
            sy_sync <= {sy_sync[0], sel_y_n};
            d_s1 <= data_in;
            d_s2 <= d_s1;
        end
    end

    // RULE7: one shift per clock rise
    assign shift_pulse = clk_sync[1] && !clk_sync[2];
    assign selected = !sx_sync[1] && !sy_sync[1];
    // RULE2: write needs both selects
    assign take_input = wr_sync[1] && selected;

    // per channel recirculation
    always_comb begin
        for (int c = 0; c < CHANNELS; c++) begin
            tail[c] = ring[c][BITS-1];
            // RULE3: recirculate unless written
            next_head[c] = take_input ? d_s2[c] : tail[c];
        end
    end

    // RULE1: 1024-bit rings, no reset by design
    always_ff @(posedge clock) begin
        if (shift_pulse) begin
            for (int c = 0; c < CHANNELS; c++) begin
                ring[c] <= {ring[c][BITS-2:0], next_head[c]};
            end
        end
    end

    // RULE4: drive output when selected
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            data_out <= '0;
            data_out_oe <= '0;
        end else begin
            data_out <= tail;
            data_out_oe <= {CHANNELS{selected}};
        end
    end
    assign unused_out_in = ^data_out_in;

    // RULE5: shift spacing watch
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gap_cnt <= GAP;
            rate_fault <= 1'b0;
        end else if (shift_pulse) begin
            rate_fault <= rate_fault || (gap_cnt < GAP);
            gap_cnt <= '0;
        end else if (gap_cnt < GAP) begin
            gap_cnt <= gap_cnt + 1'b1;
        end
    end

    // RULE6: storage hold time watch
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hold_cnt <= '0;
            hold_fault <= 1'b0;
        end else if (shift_pulse) begin
            hold_cnt <= '0;
        end else if (hold_cnt < HOLD) begin
            hold_cnt <= hold_cnt + 1'b1;
        end else begin
            hold_fault <= 1'b1;
        end
    end

    // staging of read bits while selected
    rsreg_fifo #(
        .WIDTH(CHANNELS),
        .DEPTH(DEPTH)
    ) u_stage (
        .clock(clock),
        .rst_n(rst_n),
        .in_valid(shift_pulse && selected),
        .in_ready(fifo_in_ready),
        .in_data(tail),
        .out_valid(bit_valid),
        .out_ready(bit_ready),
        .out_data(bit_data)
    );

    // sticky loss of a staged bit
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage_overflow <= 1'b0;
        end else if (shift_pulse && selected && !fifo_in_ready) begin
            stage_overflow <= 1'b1;
        end
    end

    // RULE2: written bit enters head
    AST_WRITE_HEAD: assert property (@(posedge clock) disable iff (!rst_n) // RULE2
        shift_pulse && take_input |=> ring[0][0] == $past(d_s2[0])) else $error("input bit not written");
    // RULE1: last channel written on its own
    AST_WRITE_LAST: assert property (@(posedge clock) disable iff (!rst_n) // RULE1
        shift_pulse && take_input |=> ring[CHANNELS-1][0] == $past(d_s2[CHANNELS-1]))
        else $error("last channel bit not written");
    // RULE3: recirculated bit enters head
    AST_RECIRC_HEAD: assert property (@(posedge clock) disable iff (!rst_n) // RULE3
        shift_pulse && !take_input |=> ring[0][0] === $past(tail[0])) else $error("bit not recirculated");
    // RULE1: last channel recirculates alone
    AST_RECIRC_LAST: assert property (@(posedge clock) disable iff (!rst_n) // RULE1
        shift_pulse && !take_input |=> ring[CHANNELS-1][0] === $past(tail[CHANNELS-1]))
        else $error("last channel bit not recirculated");
    // RULE7: ring[0][1] holds between shifts, unwritten X value included
    AST_HOLD_STILL: assert property (@(posedge clock) disable iff (!rst_n) // RULE7
        !shift_pulse |=> ring[0][1] === $past(ring[0][1])) else $error("ring moved without clock");
    // RULE7: tail holds between shifts
    AST_TAIL_STILL: assert property (@(posedge clock) disable iff (!rst_n) // RULE7
        !shift_pulse |=> tail[0] === $past(tail[0])) else $error("tail moved without clock");
    // RULE7: shift moves bit one place
    AST_ONE_STEP: assert property (@(posedge clock) disable iff (!rst_n) // RULE7
        shift_pulse |=> ring[0][1] === $past(ring[0][0])) else $error("shift not by one");
    // RULE7: tail takes the next bit
    AST_TAIL_STEP: assert property (@(posedge clock) disable iff (!rst_n) // RULE7
        shift_pulse |=> tail[0] === $past(ring[0][BITS-2])) else $error("tail not advanced by one");
    // RULE4: enable follows selects
    AST_OE_SELECT: assert property (@(posedge clock) disable iff (!rst_n) // RULE4
        selected |=> data_out_oe[0]) else $error("selected output not driven");
    // RULE4: deselected line released
    AST_OE_RELEASE: assert property (@(posedge clock) disable iff (!rst_n) // RULE4
        !selected |=> !data_out_oe[0]) else $error("deselected output driven");
    // RULE4: last channel enable follows selects
    AST_OE_LAST: assert property (@(posedge clock) disable iff (!rst_n) // RULE4
        selected |=> data_out_oe[CHANNELS-1]) else $error("selected last output not driven");
    // RULE4: last channel released when deselected
    AST_OE_LAST_RELEASE: assert property (@(posedge clock) disable iff (!rst_n) // RULE4
        !selected |=> !data_out_oe[CHANNELS-1]) else $error("deselected last output driven");
    // RULE4: output shows tail bit
    AST_OUT_TAIL: assert property (@(posedge clock) disable iff (!rst_n) // RULE4
        data_out_oe[0] |-> data_out[0] === $past(tail[0])) else $error("output not register tail");
    // RULE5: fast shifts flagged
    AST_RATE_FLAG: assert property (@(posedge clock) disable iff (!rst_n) // RULE5
        shift_pulse && gap_cnt < GAP |=> rate_fault) else $error("fast shift not flagged");
    // RULE6: long stall flagged
    AST_HOLD_FLAG: assert property (@(posedge clock) disable iff (!rst_n) // RULE6
        hold_cnt == HOLD && !shift_pulse |=> hold_fault) else $error("stall not flagged");

    COV_WRITE: cover property (@(posedge clock) disable iff (!rst_n) shift_pulse && take_input);
    COV_RECIRC_SEL: cover property (@(posedge clock) disable iff (!rst_n) shift_pulse && selected && !take_input);
    COV_DESEL: cover property (@(posedge clock) disable iff (!rst_n) shift_pulse && !selected);
    COV_FULL: cover property (@(posedge clock) disable iff (!rst_n) !fifo_in_ready);
    COV_FAST: cover property (@(posedge clock) disable iff (!rst_n) shift_pulse && gap_cnt < GAP);
endmodule

/* hw/rsreg_fifo.sv */
// small valid/ready fifo in flip-flops
`timescale 1ns/10ps
module rsreg_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_idx;
    logic [AW-1:0] rd_idx;
    logic [AW:0] count;
    logic push;
    logic pop;

    // handshakes
    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_idx];

    // storage write
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_idx] <= in_data;
        end
    end

    // pointers and fill level
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_idx <= '0;
            rd_idx <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_idx <= (wr_idx == AW'(DEPTH - 1)) ? '0 : wr_idx + 1'b1;
            end
            if (pop) begin
                rd_idx <= (rd_idx == AW'(DEPTH - 1)) ? '0 : rd_idx + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    AST_FIFO_NO_OVERFLOW: assert property (@(posedge clock) disable iff (!rst_n)
        count <= (AW+1)'(DEPTH)) else $error("fifo level above depth");
endmodule

/* hw/rsreg_pkg.sv */
// shared constants for the recirculating shift register block
package rsreg_pkg;
    // channel length in bits
    localparam int CHAN_BITS = 1024;
    // channel count of the dual build
    localparam int CHAN_COUNT = 2;
    // system clock rate
    localparam int CLK_HZ = 10000000;
    // fastest allowed shift rate
    localparam int MAX_SHIFT_HZ = 1000000;
    // least system cycles between two shifts, rounded up
    localparam int SHIFT_GAP_CYC = (CLK_HZ + MAX_SHIFT_HZ - 1) / MAX_SHIFT_HZ;
    // slowest allowed shift rate, ceramic and plastic packages
    localparam int MIN_SHIFT_HZ = 1000;
    localparam int MIN_SHIFT_HZ_PLASTIC = 100000;
    // longest system cycles between shifts before contents are lost
    localparam int HOLD_MAX_CYC = CLK_HZ / MIN_SHIFT_HZ;
    // staging fifo shape
    localparam int FIFO_DEPTH = 4;
endpackage

/* tb/recirculating_shift_register_test.sv */
// self-checking bench for the recirculating shift register
`timescale 1ns/10ps
module recirculating_shift_register_test;
    localparam int BITS = 8;
    localparam logic [7:0] PAT0 = 8'hB4;
    localparam logic [7:0] PAT1 = 8'h3C;
    logic clock, rst_n, shift_clk, write_en, sel_x_n, sel_y_n, bit_ready, bit_valid;
    logic rate_fault, hold_fault, stage_overflow;
    logic [1:0] data_in, data_out, data_out_oe, data_out_in, bit_data;
    int fail_count = 0;
    int compares = 0;

    // shared line with pull-up when released
    assign data_out_in = (data_out & data_out_oe) | ~data_out_oe;

    rsreg_core #(.BITS(BITS), .HOLD_MAX(200)) u_rsreg_core (.clock(clock), .rst_n(rst_n),
        .shift_clk(shift_clk), .data_in(data_in), .write_en(write_en), .sel_x_n(sel_x_n),
        .sel_y_n(sel_y_n), .data_out(data_out), .data_out_oe(data_out_oe), .data_out_in(data_out_in),
        .bit_valid(bit_valid), .bit_ready(bit_ready), .bit_data(bit_data), .rate_fault(rate_fault),
        .hold_fault(hold_fault), .stage_overflow(stage_overflow));
    rsreg_ttl_ctrl u_rsreg_ttl_ctrl (.clock(clock), .shift_clk(shift_clk), .data_in(data_in),
        .write_en(write_en), .sel_x_n(sel_x_n), .sel_y_n(sel_y_n));

    // compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // pattern bit pair at position i
    function automatic logic [1:0] pbit(input int i);
        return {PAT1[i], PAT0[i]};
    endfunction

    // eight selected recirculating shifts, pattern must come back
    task automatic read_all();
        for (int i = 0; i < BITS; i++) begin
            chk({6'h0, data_out}, {6'h0, pbit(i)});
            u_rsreg_ttl_ctrl.shift(~pbit(i), 1'b0, 1'b0, 1'b0, 5);
            chk({6'h0, data_out_oe}, 8'h03);
        end
    endtask

    task automatic t_write_read();
        for (int i = 0; i < BITS; i++) begin
            u_rsreg_ttl_ctrl.shift(pbit(i), 1'b1, 1'b0, 1'b0, 5);
            chk({6'h0, data_out_oe}, 8'h03);
        end
        read_all();
        $display("test write_read done");
    endtask

    task automatic t_deselect();
        for (int i = 0; i < BITS; i++) begin
            u_rsreg_ttl_ctrl.shift(~pbit(i), 1'b1, i < 4, i >= 4, 5);
            chk({6'h0, data_out_oe}, 8'h00);
        end
        read_all();
        $display("test deselect done");
    endtask

    task automatic t_fifo();
        bit_ready = 1'b0;
        for (int i = 0; i < 5; i++) begin
            u_rsreg_ttl_ctrl.shift(~pbit(i), 1'b0, 1'b0, 1'b0, 5);
            chk({7'h0, stage_overflow}, {7'h0, i == 4});
        end
        bit_ready = 1'b1;
        for (int i = 0; i < 4; i++) begin
            chk({7'h0, bit_valid}, 8'h01);
            chk({6'h0, bit_data}, {6'h0, pbit(i)});
            @(posedge clock);
            #1;
        end
        chk({7'h0, bit_valid}, 8'h00);
        for (int i = 5; i < BITS; i++) begin
            chk({6'h0, data_out}, {6'h0, pbit(i)});
            u_rsreg_ttl_ctrl.shift(~pbit(i), 1'b0, 1'b0, 1'b0, 5);
        end
        $display("test fifo done");
    endtask

    task automatic t_faults();
        chk({6'h0, rate_fault, hold_fault}, 8'h00);
        u_rsreg_ttl_ctrl.shift(2'h0, 1'b0, 1'b0, 1'b0, 2);
        u_rsreg_ttl_ctrl.shift(2'h0, 1'b0, 1'b0, 1'b0, 2);
        // flag lands two edges after the clock pin rise is seen
        repeat (2) @(posedge clock);
        #1;
        chk({7'h0, rate_fault}, 8'h01);
        repeat (250) @(posedge clock);
        #1;
        chk({7'h0, hold_fault}, 8'h01);
        rst_n = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        chk({4'h0, rate_fault, hold_fault, data_out_oe}, 8'h00);
        rst_n = 1'b1;
        $display("test faults done");
    endtask

    task automatic end_of_test();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // clock
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // watchdog
    initial begin
        repeat (5000) @(posedge clock);
        fail_count++;
        $display("watchdog expired");
        end_of_test();
    end

    // main sequence
    initial begin
        rst_n = 1'b0;
        bit_ready = 1'b1;
        repeat (16) @(posedge clock);
        #1;
        rst_n = 1'b1;
        t_write_read();
        t_deselect();
        t_fifo();
        t_faults();
        end_of_test();
    end
endmodule

/* tb/rsreg_ttl_ctrl.sv */
// ttl control logic model driving the shift register pins
`timescale 1ns/10ps
module rsreg_ttl_ctrl (
    // clock
    input wire logic clock,
    // pins toward the register
    output logic shift_clk,
    output logic [1:0] data_in,
    output logic write_en,
    output logic sel_x_n,
    output logic sel_y_n
);
    // idle pins, both selects off
    initial begin
        shift_clk = 1'b0;
        data_in = 2'h0;
        write_en = 1'b0;
        sel_x_n = 1'b1;
        sel_y_n = 1'b1;
    end

    // one shift: pins set, held n cycles, clock high n cycles
    // with n of 5 shifts sit 11 cycles apart
    // callers keep shifting except in the faults test
    task automatic shift(input logic [1:0] din, input logic we, input logic sx, input logic sy, input int n);
        @(posedge clock);
        #1;
        data_in = din;
        write_en = we;
        sel_x_n = sx;
        sel_y_n = sy;
        repeat (n) @(posedge clock);
        #1;
        shift_clk = 1'b1;
        repeat (n) @(posedge clock);
        #1;
        shift_clk = 1'b0;
        data_in = ~din; // stale data line flips after hold
    endtask
endmodule
